// file: inc/bit_skip_pkg.sv
package bit_skip_pkg;
	// opcode first bytes
	localparam logic [7:0] OP_SKIP_CARRY = 8'hD7;
	localparam logic [7:0] OP_SET_MEM = 8'hF9;
	localparam logic [7:0] OP_CLR_MEM = 8'hF8;
	localparam logic [7:0] OP_SETZ_MEM = 8'hFD;
	localparam logic [7:0] OP_XOR_MEM = 8'hF7;
	// direct form: 11 b1 b0 00 1x, low nibble selects the test sense
	localparam logic [1:0] DIR_TOP = 2'b11;
	localparam logic [3:0] DIR_SET_LO = 4'h3;
	localparam logic [3:0] DIR_CLR_LO = 4'h2;
	// second byte top bits
	localparam logic [1:0] SB_HPAGE = 2'b00;
	localparam logic [1:0] SB_INDEX = 2'b01;
	localparam logic [1:0] SB_WIN_LO = 2'b10;
	localparam logic [1:0] SB_WIN_HI = 2'b11;
	// memory-mapped bit windows, upper byte of the 12-bit address
	localparam logic [7:0] WIN_LO_PAGE = 8'hFB;
	localparam logic [7:0] WIN_HI_PAGE = 8'hFF;
	localparam logic [3:0] IDX_PAGE = 4'hF;
	localparam logic [3:0] BANK0 = 4'h0;
	// cycle costs before any skip
	localparam logic [1:0] CYC_SHORT = 2'd1;
	localparam logic [1:0] CYC_LONG = 2'd2;
	typedef enum logic [1:0] {OPK_SET, OPK_CLR, OPK_SETZ, OPK_XOR} op_kind_t;
	typedef enum logic [1:0] {ST_FETCH, ST_OPERAND, ST_READ, ST_DONE} exec_state_t;
endpackage : bit_skip_pkg

// file: hw/bit_addr_gen.sv
module bit_addr_gen
	import bit_skip_pkg::*;
(
	// operand
	input wire logic [7:0] op2_i,
	input wire logic [3:0] h_reg_i,
	input wire logic [3:0] l_reg_i,
	input wire logic [3:0] bank_i,
	// result
	output logic [11:0] addr_o,
	output logic [1:0] bit_o
);
	wire [1:0] form = op2_i[7:6];
	// h-paged form always lands in bank 0, the bank flag is ignored
	wire [11:0] hpage_addr = {BANK0, h_reg_i, op2_i[3:0]};
	// indexed bytes sit in the top quarter of the page, hence the fixed 11 above the nibble
	wire [11:0] index_addr = {IDX_PAGE, 2'h3, op2_i[3:0], l_reg_i[3:2]};
	wire [11:0] win_addr = {(form == SB_WIN_HI) ? WIN_HI_PAGE : WIN_LO_PAGE, op2_i[3:0]};
	wire [11:0] direct_addr = {bank_i, op2_i};

	assign addr_o = (form == SB_HPAGE) ? hpage_addr :
		(form == SB_INDEX) ? index_addr : win_addr;
	assign bit_o = (form == SB_INDEX) ? l_reg_i[1:0] : op2_i[5:4];
	wire unused_direct = ^direct_addr;
endmodule : bit_addr_gen

// file: hw/bit_skip_exec.sv
module bit_skip_exec
	import bit_skip_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// instruction stream
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	// cpu registers
	input wire logic [3:0] h_reg_i,
	input wire logic [3:0] l_reg_i,
	input wire logic ext_bank_enable_flag_i,
	input wire logic [3:0] bank_sel_i,
	input wire logic carry_i,
	// data memory nibble port
	input wire logic [3:0] mem_rdata_i,
	output logic [11:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [3:0] mem_wdata_o,
	// results
	output logic carry_we_o,
	output logic carry_o,
	output logic skip_o,
	output logic done_o,
	output logic [1:0] cycles_o,
	output logic busy_o
);
	exec_state_t state_r, state_nxt;
	op_kind_t kind_r;
	logic direct_r;
	logic [7:0] op2_r;
	logic [11:0] mem_addr_r;
	logic [1:0] bit_r;
	logic mem_rd_r, mem_wr_r;
	logic [3:0] mem_wdata_r;
	logic carry_we_r, carry_r, skip_r, done_r;
	logic [1:0] cycles_r;
	logic busy_r;

	wire [11:0] gen_addr;
	wire [1:0] gen_bit;
	bit_addr_gen u_addr (
		.op2_i(byte_i),
		.h_reg_i(h_reg_i),
		.l_reg_i(l_reg_i),
		.bank_i(bank_sel_i),
		.addr_o(gen_addr),
		.bit_o(gen_bit)
	);

	// first-byte decode
	wire is_carry_test = byte_i == OP_SKIP_CARRY;
	// the direct form may name any of the four bits, so b1 b0 are not decoded
	wire is_dir = byte_i[7:6] == DIR_TOP && byte_i[3:1] == 3'b001;
	wire is_pref = byte_i == OP_SET_MEM || byte_i == OP_CLR_MEM
		|| byte_i == OP_SETZ_MEM || byte_i == OP_XOR_MEM;
	wire op_kind_t dec_kind = (byte_i == OP_CLR_MEM) ? OPK_CLR :
		(byte_i == OP_SETZ_MEM) ? OPK_SETZ :
		(byte_i == OP_XOR_MEM) ? OPK_XOR :
		(is_dir && byte_i[3:0] == DIR_CLR_LO) ? OPK_CLR : OPK_SET;
	// direct form keeps b1 b0 in the first byte; page is bank_sel_i when ext_bank_enable_flag_i is set, else bank 0
	wire dir_bank_zero = !ext_bank_enable_flag_i;
	wire [11:0] dir_addr = {dir_bank_zero ? BANK0 : bank_sel_i, byte_i};
	// the indexed operand has 00 above its nibble; a refused operand drops the instruction
	wire form_ok = direct_r || byte_i[7:6] != SB_INDEX || byte_i[5:4] == 2'h0;
	// an operand byte that is taken starts the read
	wire take_operand = state_r == ST_OPERAND && byte_valid_i && form_ok;

	// tested bit
	wire tested = mem_rdata_i[bit_r];
	wire do_skip = (kind_r == OPK_CLR) ? !tested : tested;
	wire [3:0] clr_mask = ~(4'h1 << bit_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_FETCH:
				if (byte_valid_i && (is_pref || is_dir))
					state_nxt = ST_OPERAND;
			ST_OPERAND:
				if (byte_valid_i)
					state_nxt = form_ok ? ST_READ : ST_FETCH;
			ST_READ:
				state_nxt = ST_FETCH;
			ST_DONE:
				state_nxt = ST_FETCH;
			default:
				state_nxt = ST_FETCH;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_r <= ST_FETCH;
			kind_r <= OPK_SET;
			direct_r <= 1'b0;
			op2_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_FETCH && byte_valid_i) begin
				kind_r <= dec_kind;
				direct_r <= is_dir;
				op2_r <= byte_i;
			end
		end
	end

	// address capture: direct form takes the second byte as the low byte and the page from dir_addr
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mem_addr_r <= 12'h000;
			bit_r <= 2'b00;
		end else if (take_operand) begin
			mem_addr_r <= direct_r ? {dir_addr[11:8], byte_i} : gen_addr;
			bit_r <= direct_r ? op2_r[5:4] : gen_bit;
		end
	end

	// memory strobes: read in the cycle after the operand byte, zero-write on the skip-then-zero test
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_wdata_r <= 4'h0;
		end else begin
			mem_rd_r <= take_operand;
			mem_wr_r <= state_r == ST_READ && kind_r == OPK_SETZ;
			mem_wdata_r <= mem_rdata_i & clr_mask;
		end
	end

	// completion; only the zero test ever writes the tested bit
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			carry_we_r <= 1'b0;
			carry_r <= 1'b0;
			skip_r <= 1'b0;
			done_r <= 1'b0;
			cycles_r <= 2'd0;
		end else begin
			carry_we_r <= 1'b0;
			skip_r <= 1'b0;
			done_r <= 1'b0;
			if (state_r == ST_FETCH && byte_valid_i && is_carry_test) begin
				skip_r <= carry_i;
				done_r <= 1'b1;
				cycles_r <= CYC_SHORT;
			end else if (state_r == ST_READ) begin
				done_r <= 1'b1;
				cycles_r <= CYC_LONG;
				if (kind_r == OPK_XOR) begin
					carry_we_r <= 1'b1;
					carry_r <= carry_i ^ tested;
				end else begin
					skip_r <= do_skip;
				end
			end
		end
	end

	// busy is registered from the next state so the output never glitches
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= state_nxt != ST_FETCH;
		end
	end

	assign mem_addr_o = mem_addr_r;
	assign mem_rd_o = mem_rd_r;
	assign mem_wr_o = mem_wr_r;
	assign mem_wdata_o = mem_wdata_r;
	assign carry_we_o = carry_we_r;
	assign carry_o = carry_r;
	assign skip_o = skip_r;
	assign done_o = done_r;
	assign cycles_o = cycles_r;
	assign busy_o = busy_r;

	// a memory-form instruction: first byte, operand byte, then one read cycle
	sequence s_take_first;
		state_r == ST_FETCH && byte_valid_i && (is_pref || is_dir);
	endsequence
	sequence s_mem_op;
		take_operand ##1 state_r == ST_READ;
	endsequence
	sequence s_mem_whole;
		s_take_first ##1 take_operand;
	endsequence

	// one-byte carry test
	chk_carry_skip_cost: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_FETCH && byte_valid_i && is_carry_test
		|=> done_o && skip_o == $past(carry_i) && cycles_o == CYC_SHORT)
		else $error("carry test result wrong");
	chk_carry_one_byte: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_FETCH && byte_valid_i && is_carry_test
		|=> !busy_o && !mem_rd_o)
		else $error("carry test waited for an operand byte");

	// timing of the memory forms
	chk_read_step: assert property (
		@(posedge clock_i) disable iff (rst_i)
		s_mem_whole
		|-> busy_o ##1 (mem_rd_o && busy_o))
		else $error("operand read not issued after the second byte");
	chk_mem_two_cycle: assert property (
		@(posedge clock_i) disable iff (rst_i)
		s_mem_op
		|=> done_o && cycles_o == CYC_LONG && !busy_o)
		else $error("memory form did not finish in two cycles");
	chk_rd_pulse: assert property (
		@(posedge clock_i) disable iff (rst_i)
		mem_rd_o
		|=> !mem_rd_o)
		else $error("operand read lasted more than one cycle");

	// skip decisions
	chk_set_skip: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_READ && kind_r == OPK_SET
		|=> skip_o == $past(tested))
		else $error("skip-if-set decision wrong");
	chk_clr_skip: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_READ && kind_r == OPK_CLR
		|=> skip_o == !$past(tested))
		else $error("skip-if-clear decision wrong");
	chk_setz_skip: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_READ && kind_r == OPK_SETZ
		|=> skip_o == $past(tested))
		else $error("skip-then-zero decision wrong");

	// side effects on the tested bit and the carry
	chk_zero_write: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_READ && kind_r == OPK_SETZ
		|=> mem_wr_o && mem_wdata_o == ($past(mem_rdata_i) & ~(4'h1 << bit_r)))
		else $error("zero test did not clear only the tested bit");
	chk_wr_pulse: assert property (
		@(posedge clock_i) disable iff (rst_i)
		mem_wr_o
		|=> !mem_wr_o)
		else $error("bit write lasted more than one cycle");
	chk_no_write: assert property (
		@(posedge clock_i) disable iff (rst_i)
		mem_wr_o
		|-> kind_r == OPK_SETZ)
		else $error("tested bit written by non-clearing op");
	chk_xor_carry: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_READ && kind_r == OPK_XOR
		|=> carry_we_o && carry_o == ($past(carry_i) ^ $past(tested)) && !skip_o)
		else $error("carry xor result wrong");
	chk_carry_write_xor: assert property (
		@(posedge clock_i) disable iff (rst_i)
		carry_we_o
		|-> kind_r == OPK_XOR && done_o)
		else $error("carry written by an op other than carry xor");

	// operand addressing
	chk_hpage_bank: assert property (
		@(posedge clock_i) disable iff (rst_i)
		take_operand && !direct_r && byte_i[7:6] == SB_HPAGE
		|=> mem_addr_o == {BANK0, $past(h_reg_i), $past(byte_i[3:0])}
		&& bit_r == $past(byte_i[5:4]))
		else $error("h-paged address wrong");
	chk_index_addr: assert property (
		@(posedge clock_i) disable iff (rst_i)
		take_operand && !direct_r && byte_i[7:6] == SB_INDEX
		|=> mem_addr_o == {IDX_PAGE, 2'h3, $past(byte_i[3:0]), $past(l_reg_i[3:2])}
		&& bit_r == $past(l_reg_i[1:0]))
		else $error("indexed address wrong");
	chk_refuse_operand: assert property (
		@(posedge clock_i) disable iff (rst_i)
		state_r == ST_OPERAND && byte_valid_i && !form_ok
		|=> state_r == ST_FETCH && !mem_rd_o && !busy_o)
		else $error("malformed indexed operand not refused");
	chk_window_addr: assert property (
		@(posedge clock_i) disable iff (rst_i)
		take_operand && !direct_r && byte_i[7]
		|=> mem_addr_o == {($past(byte_i[6]) ? WIN_HI_PAGE : WIN_LO_PAGE), $past(byte_i[3:0])}
		&& bit_r == $past(byte_i[5:4]))
		else $error("window address wrong");
	chk_direct_addr: assert property (
		@(posedge clock_i) disable iff (rst_i)
		take_operand && direct_r
		|=> mem_addr_o[11:8] == ($past(ext_bank_enable_flag_i) ? $past(bank_sel_i) : BANK0)
		&& mem_addr_o[7:0] == $past(byte_i) && bit_r == op2_r[5:4])
		else $error("direct address wrong");
endmodule : bit_skip_exec

// file: sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bit_skip_pkg::*;
	logic clock_i, rst_i, byte_valid_i, ext_bank_enable_flag_i, carry_i;
	logic [7:0] byte_i;
	logic [3:0] h_reg_i, l_reg_i, bank_sel_i, mem_rdata_i, mem_wdata_o;
	logic [11:0] mem_addr_o;
	logic mem_rd_o, mem_wr_o, carry_we_o, carry_o, skip_o, done_o, busy_o;
	logic [1:0] cycles_o;
	logic [3:0] mem [4096];
	typedef struct packed {logic skip; logic [1:0] cyc; logic cwe; logic cval; logic wr;
		logic [3:0] wd; logic rd; logic [11:0] addr;} exp_t;
	exp_t exp_q[$];
	exp_t mon_e;
	logic rd_seen, cwe_seen, wr_seen;
	int fail_count, n_compared;
	logic [15:0] lfsr_r;
	logic [7:0] ops [4] = '{OP_SET_MEM, OP_CLR_MEM, OP_SETZ_MEM, OP_XOR_MEM};

	bit_skip_exec u_bit_skip_exec (.clock_i(clock_i), .rst_i(rst_i),
		.byte_valid_i(byte_valid_i), .byte_i(byte_i), .h_reg_i(h_reg_i), .l_reg_i(l_reg_i),
		.ext_bank_enable_flag_i(ext_bank_enable_flag_i), .bank_sel_i(bank_sel_i),
		.carry_i(carry_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
		.carry_we_o(carry_we_o), .carry_o(carry_o), .skip_o(skip_o), .done_o(done_o),
		.cycles_o(cycles_o), .busy_o(busy_o));

	// data memory answers combinationally from the presented address
	assign mem_rdata_i = mem[mem_addr_o];
	always @(posedge clock_i) if (mem_wr_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic results();
		if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	task automatic err(input string msg);
		fail_count++;
		$display("[ERR] %0t %s", $time, msg);
	endtask : err

	task automatic cmp_flag(input logic got, input logic exp, input string msg);
		n_compared++;
		if (got !== exp) err(msg);
	endtask : cmp_flag

	task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp, input string msg);
		n_compared++;
		if (got !== exp) err(msg);
	endtask : cmp_val

	function automatic logic [15:0] rnd();
		lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		return lfsr_r;
	endfunction : rnd

	task automatic send(input logic [7:0] b);
		byte_valid_i = 1'b1;
		byte_i = b;
		@(negedge clock_i);
	endtask : send

	task automatic run_op(input logic [7:0] first, input logic [7:0] op2);
		logic [15:0] r;
		logic [11:0] a;
		logic [1:0] b;
		logic bv;
		int i;
		exp_t e;
		r = rnd();
		{carry_i, ext_bank_enable_flag_i, bank_sel_i, l_reg_i, h_reg_i} = r[13:0];
		b = op2[5:4];
		if (first[3:1] == 3'b001) begin
			a = {(ext_bank_enable_flag_i ? bank_sel_i : BANK0), op2};
			b = first[5:4];
		end else case (op2[7:6])
			SB_HPAGE: a = {BANK0, h_reg_i, op2[3:0]};
			SB_INDEX: {a, b} = {IDX_PAGE, 2'b11, op2[3:0], l_reg_i};
			SB_WIN_LO: a = {WIN_LO_PAGE, op2[3:0]};
			default: a = {WIN_HI_PAGE, op2[3:0]};
		endcase
		r = rnd();
		e.rd = (first != OP_SKIP_CARRY);
		if (e.rd) mem[a] = r[3:0];
		bv = r[b];
		e.addr = a;
		e.cyc = e.rd ? CYC_LONG : CYC_SHORT;
		e.skip = (first == OP_SKIP_CARRY) ? carry_i : (first == OP_XOR_MEM) ? 1'b0 :
			(first == OP_CLR_MEM || (first[3:1] == 3'b001 && !first[0])) ? !bv : bv;
		e.cwe = (first == OP_XOR_MEM);
		e.cval = carry_i ^ bv;
		e.wr = (first == OP_SETZ_MEM);
		e.wd = r[3:0] & ~(4'h1 << b);
		exp_q.push_back(e);
		send(first);
		if (e.rd) begin
			cmp_flag(busy_o, 1'b1, "not busy between bytes");
			send(op2);
		end
		byte_valid_i = 1'b0;
		i = 0;
		while (done_o !== 1'b1 && i < 8) begin
			@(negedge clock_i);
			i++;
		end
		if (done_o !== 1'b1) err("no completion");
		// the next first byte is sent in the cycle after done_o
		@(negedge clock_i);
	endtask : run_op

	// one note per instruction; the oldest is retired when done_o pulses
	always @(negedge clock_i) if (rst_i === 1'b0) begin
		if (exp_q.size() == 0) begin
			if ((done_o | mem_rd_o | mem_wr_o | carry_we_o) !== 1'b0) err("unexpected activity");
		end else begin
			mon_e = exp_q[0];
			if (mem_rd_o === 1'b1) begin
				rd_seen = 1'b1;
				cmp_val(mem_addr_o, mon_e.addr, "bad address");
			end
			if (carry_we_o === 1'b1) begin
				cwe_seen = 1'b1;
				cmp_flag(carry_o, mon_e.cval, "bad carry");
			end
			if (mem_wr_o === 1'b1) begin
				wr_seen = 1'b1;
				cmp_val({8'h00, mem_wdata_o}, {8'h00, mon_e.wd}, "bad write data");
				cmp_val(mem_addr_o, mon_e.addr, "bad write address");
			end
			if (done_o === 1'b1) begin
				cmp_flag(skip_o, mon_e.skip, "bad skip");
				cmp_val({10'h000, cycles_o}, {10'h000, mon_e.cyc}, "bad cycles");
				cmp_flag(rd_seen, mon_e.rd, "bad read");
				cmp_flag(cwe_seen, mon_e.cwe, "bad carry write");
				cmp_flag(wr_seen, mon_e.wr, "bad bit write");
				void'(exp_q.pop_front());
				{rd_seen, cwe_seen, wr_seen} = 3'b000;
			end
		end
	end

	initial begin
		#50000;
		err("timeout");
		results();
	end

	initial begin
		logic [15:0] r;
		{rst_i, byte_valid_i, byte_i, carry_i, ext_bank_enable_flag_i} = {1'b1, 11'h000};
		{h_reg_i, l_reg_i, bank_sel_i} = 12'h000;
		{rd_seen, cwe_seen, wr_seen} = 3'b000;
		lfsr_r = 16'h61AF;
		foreach (mem[i]) mem[i] = 4'h0;
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		@(negedge clock_i);
		cmp_flag(busy_o, 1'b0, "busy after reset");
		// an unknown first byte must leave the core idle
		send(8'h01);
		byte_valid_i = 1'b0;
		repeat (3) @(negedge clock_i);
		cmp_flag(busy_o, 1'b0, "busy after unknown byte");
		// an indexed operand with its reserved bits set is refused without a read
		send(OP_SET_MEM);
		send(8'h74);
		byte_valid_i = 1'b0;
		repeat (3) @(negedge clock_i);
		cmp_flag(busy_o, 1'b0, "busy after refused operand");
		repeat (8) run_op(OP_SKIP_CARRY, 8'h00);
		for (int k = 0; k < 64; k++) begin
			r = rnd();
			if (k[3:2] == SB_INDEX) run_op(ops[k[1:0]], {4'h4, r[3:0]});
			else run_op(ops[k[1:0]], {k[3:2], r[5:0]});
		end
		for (int k = 0; k < 16; k++) begin
			r = rnd();
			run_op({DIR_TOP, r[1:0], 3'b001, r[2]}, r[15:8]);
		end
		repeat (2) @(negedge clock_i);
		results();
	end
endmodule : tb_top
